// *** logic/rfs_pkg.sv ***
`default_nettype none
package rfs_pkg;
    localparam int NREG = 11;
    localparam int NFT = 3;
    localparam int DW = 16;
    localparam int AW = 4;
    // Fault type index
    localparam int FT_ILIM = 0;
    localparam int FT_OV = 1;
    localparam int FT_UV = 2;
    // Register offsets
    localparam logic [AW-1:0] ADDR_TALLY = 4'h0;
    localparam logic [AW-1:0] ADDR_LIMIT = 4'h1;
    localparam logic [AW-1:0] ADDR_TSEL = 4'h2;
    localparam logic [AW-1:0] ADDR_IGN0 = 4'h3;
    localparam logic [AW-1:0] ADDR_KEEP0 = 4'h6;
    localparam logic [AW-1:0] ADDR_LATCH0 = 4'h9;
    localparam logic [AW-1:0] ADDR_MASK0 = 4'hC;
    localparam logic [AW-1:0] ADDR_STATUS = 4'hF;
    // Fault window codes
    localparam logic [3:0] TSEL_LAST_DBL = 4'hA;
    localparam logic [3:0] TSEL_LONG = 4'hB;
    localparam logic [11:0] TIMER_LONG_MS = 12'h808;
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int RECOV_TIME_US = 2000;
    localparam int RECOV_CYC = RECOV_TIME_US * (CLK_HZ / 1000000);
    // Reset values
    localparam logic [NREG-1:0] MASK_RST = 11'h000;
    localparam logic [NREG-1:0] KEEP_RST = 11'h000;
    typedef enum logic [1:0] {G_HOLD, G_WAIT, G_REL, G_ABORT} rfs_gate_e;
endpackage
`default_nettype wire

// *** logic/rfs_fault_supervisor.sv ***
// Contract
// RULE_01 - Host reads the tally and resets it after faults clear.
// RULE_02 - Tally equal to nonzero limit starts a power-down.
// RULE_03 - Fault limit loads its default from OTP at power-up.
// RULE_04 - Limit of zero never causes a tally power-down.
// RULE_05 - Any unbypassed regulator fault starts the fault timer.
// RULE_06 - Fault clearing before expiry resets the timer.
// RULE_07 - Fault present at timer expiry starts a power-down.
// RULE_08 - Timer select defaults from OTP and is host writable.
// RULE_09 - Codes 0-10 double from 1 ms, 11 is 2056 ms, 15 disables.
// RULE_10 - Per-regulator ignore bits for current, over and under voltage.
// RULE_11 - Ignore bits load from OTP copies at power-up.
// RULE_12 - Bypassed fault: no tally, no timer, no disable, no power-good drop.
// RULE_13 - Bypassed fault still sets latch and interrupt unless masked.
// RULE_14 - Gating off: release without power good, arm OV/UV after blanking.
// RULE_15 - Gating on: check in-range during power-up before releasing reset.
// RULE_16 - OV/UV held off until release; all enabled in range releases.
// RULE_17 - Out of range at release point: hold reset up to 2.0 ms.
// RULE_18 - Still faulty after 2.0 ms: abort, turn off enabled regulators.
// RULE_19 - Regulators enabled after release are monitored at once.
// RULE_20 - Faults after release do not stop the sequence.
// RULE_21 - Latches set on events, always readable, cleared by writing 1.
// RULE_22 - Mask bit 1 keeps its latch off the interrupt.
// RULE_23 - On each fault, tally increments while it differs from limit; here faults rising in the same cycle add only 1.
// RULE_24 - Keep-on bit 0 disables the regulator, 1 leaves it on.
// RULE_25 - Mask 0: interrupt held low while latch is set.
// RULE_26 - Interrupt is the OR of all unmasked latches.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rfs_fault_supervisor #(
    parameter int MS_CYCLES = rfs_pkg::MS_CYC,
    parameter int RECOV_CYCLES = rfs_pkg::RECOV_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [rfs_pkg::AW-1:0] regAddr,
    input wire logic [rfs_pkg::DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [rfs_pkg::DW-1:0] regRdata,
    input wire logic powerUpStart,
    input wire logic [3:0] otpFaultLimitDefault,
    input wire logic [3:0] otpTimerSel,
    input wire logic [rfs_pkg::NREG-1:0] otpIgnIlim,
    input wire logic [rfs_pkg::NREG-1:0] otpIgnOv,
    input wire logic [rfs_pkg::NREG-1:0] otpIgnUv,
    input wire logic otpPowergoodGating,
    input wire logic [rfs_pkg::NREG-1:0] faultIlim,
    input wire logic [rfs_pkg::NREG-1:0] faultOv,
    input wire logic [rfs_pkg::NREG-1:0] faultUv,
    input wire logic [rfs_pkg::NREG-1:0] inRange,
    input wire logic [rfs_pkg::NREG-1:0] blankDone,
    input wire logic [rfs_pkg::NREG-1:0] enabledSoFar,
    input wire logic releaseDue,
    output logic hostResetOutN,
    output logic powerGoodOut,
    output logic irqOutN,
    output logic [rfs_pkg::NREG-1:0] regDisable,
    output logic seqPause,
    output logic powerUpAbort,
    output logic powerDownReq
);
    import rfs_pkg::*;

    logic [NREG-1:0] cond [NFT];
    logic [NREG-1:0] mon [NFT];
    logic [NREG-1:0] act [NFT];
    logic [NREG-1:0] rise [NFT];
    logic [NREG-1:0] monPrev_r [NFT];
    logic [NREG-1:0] ign_r [NFT];
    logic [NREG-1:0] keep_r [NFT];
    logic [NREG-1:0] latch_r [NFT];
    logic [NREG-1:0] mask_r [NFT];
    logic [3:0] tally_r;
    logic [3:0] limit_r;
    logic [3:0] tsel_r;
    logic pgGate_r;
    logic evt;
    logic anyAct;
    logic ovUvAct;
    logic tallyWr;
    logic tallyMax;
    logic tallyMaxPrev_r;
    logic [11:0] limitMs;
    logic tmrRun_r;
    logic tmrDone_r;
    logic [15:0] msCnt_r;
    logic [11:0] tmrMs_r;
    logic pdTimer;
    rfs_gate_e gate_r;
    rfs_gate_e gateNxt;
    logic [15:0] recCnt_r;
    logic allGood;
    logic recExp;
    logic [NREG-1:0] pgFail;
    logic [NREG-1:0] pgFailPrev_r;
    logic [NREG-1:0] pending;
    logic [NREG-1:0] disNxt;

    ////////////////////////////////////////////////////////////////////////
    // Fault conditioning
    assign cond[FT_ILIM] = faultIlim;
    assign cond[FT_OV] = faultOv;
    assign cond[FT_UV] = faultUv;

    always_comb
    begin
        evt = 1'b0;
        anyAct = 1'b0;
        pending = '0;
        disNxt = '0;
        for (int t = 0; t < NFT; t++)
        begin
            // OV/UV stay blind until the reset is released
            if (t == FT_ILIM)
                mon[t] = cond[t]; // RULE_19
            else
                mon[t] = cond[t] & blankDone & {NREG{gate_r == G_REL}}; // RULE_14 RULE_16 RULE_19
            act[t] = mon[t] & ~ign_r[t]; // RULE_12
            rise[t] = mon[t] & ~monPrev_r[t];
            evt = evt | (|(rise[t] & ~ign_r[t])); // RULE_12
            anyAct = anyAct | (|act[t]);
            pending = pending | (latch_r[t] & ~mask_r[t]); // RULE_22 RULE_26
            disNxt = disNxt | (act[t] & ~keep_r[t]); // RULE_24
        end
    end

    assign ovUvAct = |(act[FT_OV] | act[FT_UV]);

    always_ff @(posedge clk)
    begin
        for (int t = 0; t < NFT; t++)
        begin
            if (!rstn)
                monPrev_r[t] <= '0;
            else
                monPrev_r[t] <= mon[t];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            limit_r <= 4'h0;
            tsel_r <= 4'h0;
            pgGate_r <= 1'b0;
        end
        else if (powerUpStart)
        begin
            limit_r <= otpFaultLimitDefault; // RULE_03
            tsel_r <= otpTimerSel; // RULE_08
            pgGate_r <= otpPowergoodGating;
        end
        else if (regWr)
        begin
            if (regAddr == ADDR_LIMIT)
                limit_r <= regWdata[3:0];
            if (regAddr == ADDR_TSEL)
                tsel_r <= regWdata[3:0]; // RULE_08
        end
    end

    always_ff @(posedge clk)
    begin
        for (int t = 0; t < NFT; t++)
        begin
            if (!rstn)
            begin
                ign_r[t] <= '0;
                keep_r[t] <= KEEP_RST;
                mask_r[t] <= MASK_RST;
            end
            else
            begin
                if (powerUpStart)
                    ign_r[t] <= (t == FT_ILIM) ? otpIgnIlim :
                        (t == FT_OV) ? otpIgnOv : otpIgnUv; // RULE_11
                else if (regWr && regAddr == 4'(ADDR_IGN0 + t))
                    ign_r[t] <= regWdata[NREG-1:0]; // RULE_10
                if (regWr && regAddr == 4'(ADDR_KEEP0 + t))
                    keep_r[t] <= regWdata[NREG-1:0];
                if (regWr && regAddr == 4'(ADDR_MASK0 + t))
                    mask_r[t] <= regWdata[NREG-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event latches, set beats the write-one clear
    assign pgFail = (gate_r == G_WAIT) ? (enabledSoFar & ~inRange) : '0;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            pgFailPrev_r <= '0;
        else
            pgFailPrev_r <= pgFail;
    end

    always_ff @(posedge clk)
    begin
        for (int t = 0; t < NFT; t++)
        begin
            if (!rstn)
                latch_r[t] <= '0;
            else
            begin
                // Bypassed faults still latch
                latch_r[t] <= (latch_r[t] & ~((regWr && regAddr == 4'(ADDR_LATCH0 + t)) ?
                    regWdata[NREG-1:0] : '0)) | rise[t] | // RULE_13 RULE_21
                    ((t == FT_UV) ? (pgFail & ~pgFailPrev_r) : '0); // RULE_15
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            irqOutN <= 1'b1;
        else
            irqOutN <= ~(|pending); // RULE_25 RULE_26
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault tally
    assign tallyWr = regWr && regAddr == ADDR_TALLY;
    assign tallyMax = (limit_r != 4'h0) && (tally_r == limit_r); // RULE_02 RULE_04

    always_ff @(posedge clk)
    begin
        if (!rstn)
            tally_r <= 4'h0;
        else if (evt && tally_r != limit_r)
            tally_r <= tally_r + 4'h1; // RULE_23
        else if (tallyWr)
            tally_r <= 4'h0; // RULE_01
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            tallyMaxPrev_r <= 1'b0;
        else
            tallyMaxPrev_r <= tallyMax;
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault timer, reserved codes behave as disabled
    always_comb
    begin
        if (tsel_r <= TSEL_LAST_DBL)
            limitMs = 12'h001 << tsel_r; // RULE_09
        else if (tsel_r == TSEL_LONG)
            limitMs = TIMER_LONG_MS; // RULE_09
        else
            limitMs = 12'h000; // RULE_09
    end

    assign pdTimer = tmrRun_r && (msCnt_r == 16'(MS_CYCLES - 1)) &&
        (tmrMs_r == limitMs - 12'h001);

    always_ff @(posedge clk)
    begin
        if (!rstn || !anyAct || limitMs == 12'h000)
        begin
            tmrRun_r <= 1'b0; // RULE_06
            tmrDone_r <= 1'b0;
            msCnt_r <= 16'h0000;
            tmrMs_r <= 12'h000;
        end
        else if (!tmrRun_r && !tmrDone_r)
            tmrRun_r <= 1'b1; // RULE_05
        else if (pdTimer)
        begin
            tmrRun_r <= 1'b0; // RULE_07
            tmrDone_r <= 1'b1;
        end
        else if (tmrRun_r)
        begin
            if (msCnt_r == 16'(MS_CYCLES - 1))
            begin
                msCnt_r <= 16'h0000;
                tmrMs_r <= tmrMs_r + 12'h001;
            end
            else
                msCnt_r <= msCnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            powerDownReq <= 1'b0;
        else
            powerDownReq <= pdTimer || (tallyMax && !tallyMaxPrev_r); // RULE_02 RULE_07
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release gating
    assign allGood = &(inRange | ~enabledSoFar); // RULE_16
    assign recExp = recCnt_r == 16'(RECOV_CYCLES - 1);

    always_comb
    begin
        gateNxt = gate_r;
        unique case (gate_r)
            G_HOLD:
                if (releaseDue)
                begin
                    if (!pgGate_r || allGood)
                        gateNxt = G_REL; // RULE_14 RULE_15 RULE_16
                    else
                        gateNxt = G_WAIT; // RULE_17
                end
            G_WAIT:
                if (allGood)
                    gateNxt = G_REL; // RULE_17
                else if (recExp)
                    gateNxt = G_ABORT; // RULE_18
            G_REL:
                gateNxt = G_REL; // RULE_20
            G_ABORT:
                gateNxt = G_ABORT;
        endcase
        if (powerUpStart)
            gateNxt = G_HOLD;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            gate_r <= G_HOLD;
        else
            gate_r <= gateNxt;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn || gate_r != G_WAIT)
            recCnt_r <= 16'h0000;
        else if (!recExp)
            recCnt_r <= recCnt_r + 16'h0001;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            hostResetOutN <= 1'b0;
            seqPause <= 1'b0;
            powerUpAbort <= 1'b0;
            powerGoodOut <= 1'b0;
            regDisable <= '0;
        end
        else
        begin
            hostResetOutN <= gateNxt == G_REL;
            seqPause <= gateNxt == G_WAIT; // RULE_17 RULE_20
            powerUpAbort <= gate_r == G_WAIT && gateNxt == G_ABORT; // RULE_18
            powerGoodOut <= gate_r == G_REL && !ovUvAct; // RULE_12
            // Abort drops every regulator enabled so far
            regDisable <= disNxt | ((gate_r == G_ABORT) ? enabledSoFar : '0); // RULE_18 RULE_24
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, all 16 offsets mapped; data reads zero while regRd is low
    always_ff @(posedge clk)
    begin
        if (!rstn)
            regRdata <= '0;
        else if (!regRd)
            regRdata <= '0;
        else
        begin
            regRdata <= '0;
            unique case (regAddr)
                ADDR_TALLY: regRdata[3:0] <= tally_r;
                ADDR_LIMIT: regRdata[3:0] <= limit_r;
                ADDR_TSEL: regRdata[3:0] <= tsel_r;
                ADDR_STATUS: regRdata[5:0] <= {gate_r, tmrRun_r, tmrDone_r, pgGate_r, tallyMax};
                default:
                    for (int t = 0; t < NFT; t++)
                    begin
                        if (regAddr == 4'(ADDR_IGN0 + t))
                            regRdata[NREG-1:0] <= ign_r[t];
                        if (regAddr == 4'(ADDR_KEEP0 + t))
                            regRdata[NREG-1:0] <= keep_r[t];
                        if (regAddr == 4'(ADDR_LATCH0 + t))
                            regRdata[NREG-1:0] <= latch_r[t]; // RULE_21
                        if (regAddr == 4'(ADDR_MASK0 + t))
                            regRdata[NREG-1:0] <= mask_r[t];
                    end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_tally_pd: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        $rose(tallyMax) |=> powerDownReq) else $error("tally max without power-down");
    a_zero_limit: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
        limit_r == 4'h0 && !pdTimer |=> !powerDownReq) else $error("zero limit powered down");
    a_tmr_start: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
        anyAct && limitMs != 12'h000 && !tmrDone_r && !powerUpStart |=> tmrRun_r || tmrDone_r)
        else $error("fault timer not running");
    a_tmr_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        !anyAct |=> !tmrRun_r && tmrMs_r == 12'h000) else $error("timer not reset");
    a_tmr_expire: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
        pdTimer |=> powerDownReq ##1 !tmrRun_r || !anyAct) else $error("expiry lost");
    a_byp_tally: assert property (@(posedge clk) disable iff (!rstn) // RULE_12
        !evt && !tallyWr |=> $stable(tally_r)) else $error("tally moved without fault");
    a_w1c_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE_21
        regWr && regAddr == ADDR_LATCH0 && regWdata[0] && !rise[FT_ILIM][0]
        |=> !latch_r[FT_ILIM][0]) else $error("latch not cleared");
    a_irq_or: assert property (@(posedge clk) disable iff (!rstn) // RULE_26
        |pending |=> !irqOutN) else $error("interrupt not asserted");
    a_abort_win: assert property (@(posedge clk) disable iff (!rstn) // RULE_18
        gate_r == G_WAIT && recExp && !allGood && !powerUpStart
        |=> powerUpAbort && gate_r == G_ABORT) else $error("no abort at window end");
    a_pg_release: assert property (@(posedge clk) disable iff (!rstn) // RULE_15
        $rose(hostResetOutN) && pgGate_r |-> $past(allGood)) else $error("released out of range");
    a_keep_off: assert property (@(posedge clk) disable iff (!rstn) // RULE_24
        act[FT_ILIM][0] && !keep_r[FT_ILIM][0] |=> regDisable[0]) else $error("not disabled");

    c_tally_pd: cover property (@(posedge clk) disable iff (!rstn) $rose(tallyMax));
    c_tmr_exp: cover property (@(posedge clk) disable iff (!rstn) pdTimer);
    c_abort: cover property (@(posedge clk) disable iff (!rstn) powerUpAbort);
    c_wait_rel: cover property (@(posedge clk) disable iff (!rstn)
        gate_r == G_WAIT ##1 gate_r == G_REL);
endmodule
`default_nettype wire

// *** sim/rfs_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rfs_host_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic irqOutN,
    input wire logic hostResetOutN,
    output int irqCount,
    output logic hostAwake
);
    logic irqPrevN;
    ////////////////////////////////////////////////////////////////////////////////
    // Host counts falling edges and follows reset release; it reacts through the bench's bus tasks
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            irqCount <= 0;
            irqPrevN <= 1'b1;
            hostAwake <= 1'b0;
        end
        else
        begin
            irqPrevN <= irqOutN;
            hostAwake <= hostResetOutN;
            if (irqPrevN && !irqOutN)
                irqCount <= irqCount + 1;
        end
    end
endmodule
`default_nettype wire

// *** sim/rfs_fault_supervisor_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nErrors++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module rfs_fault_supervisor_bench;
    import rfs_pkg::*;
    localparam int MSC = 4;
    logic clk, rstn, regWr, regRd, powerUpStart, otpPowergoodGating, releaseDue;
    logic [AW-1:0] regAddr;
    logic [DW-1:0] regWdata, regRdata, v;
    logic [3:0] otpFaultLimitDefault, otpTimerSel;
    logic [NREG-1:0] otpIgnIlim, faultIlim, faultOv, faultUv, inRange, enabledSoFar;
    logic [NREG-1:0] regDisable, otpIgnOv, otpIgnUv;
    logic hostResetOutN, powerGoodOut, irqOutN, seqPause, powerUpAbort, powerDownReq;
    logic hostAwake;
    int nErrors = 0, numChecks = 0, pdCount = 0, abCount = 0, irqCount, n, p0, i0;
    ////////////////////////////////////////////////////////////////////////////////
    rfs_fault_supervisor #(.MS_CYCLES(MSC), .RECOV_CYCLES(8)) i_dut (
        .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .powerUpStart(powerUpStart),
        .otpFaultLimitDefault(otpFaultLimitDefault), .otpTimerSel(otpTimerSel),
        .otpIgnIlim(otpIgnIlim), .otpIgnOv(otpIgnOv), .otpIgnUv(otpIgnUv),
        .otpPowergoodGating(otpPowergoodGating), .faultIlim(faultIlim), .faultOv(faultOv),
        .faultUv(faultUv), .inRange(inRange), .blankDone(enabledSoFar),
        .enabledSoFar(enabledSoFar), .releaseDue(releaseDue), .hostResetOutN(hostResetOutN),
        .powerGoodOut(powerGoodOut), .irqOutN(irqOutN), .regDisable(regDisable),
        .seqPause(seqPause), .powerUpAbort(powerUpAbort), .powerDownReq(powerDownReq));
    rfs_host_model i_host (.clk(clk), .rstn(rstn), .irqOutN(irqOutN),
        .hostResetOutN(hostResetOutN), .irqCount(irqCount), .hostAwake(hostAwake));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // One-cycle pulses are counted here so no test can miss them
    always @(posedge clk)
    begin
        pdCount <= pdCount + (powerDownReq === 1'b1);
        abCount <= abCount + (powerUpAbort === 1'b1);
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic powerUp(input logic [3:0] lim, input logic [3:0] ts, input logic gate);
        @(posedge clk);
        otpFaultLimitDefault <= lim;
        otpTimerSel <= ts;
        otpPowergoodGating <= gate;
        powerUpStart <= 1'b1;
        @(posedge clk);
        powerUpStart <= 1'b0;
    endtask
    // Held fault on regulator 0; cycles until the power-down pulse, capped
    task automatic timeFault(input logic [3:0] code, input int cap);
        wr(ADDR_TSEL, {12'h000, code});
        p0 = pdCount;
        faultIlim <= 11'h001;
        n = 0;
        while (pdCount == p0 && n < cap)
        begin
            @(posedge clk);
            n++;
        end
        faultIlim <= 11'h000;
        wr(ADDR_LATCH0, 16'h07FF);
        wr(ADDR_TALLY, 16'h0000);
    endtask
    task automatic pulses(input int k);
        repeat (k)
        begin
            @(posedge clk);
            faultIlim <= 11'h004;
            cyc(2);
            faultIlim <= 11'h000;
            cyc(2);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d, errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #(40 * 40000);
        nErrors++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn <= 1'b0; regWr <= 1'b0; regRd <= 1'b0; regAddr <= 4'h0; regWdata <= 16'h0000;
        powerUpStart <= 1'b0; otpFaultLimitDefault <= 4'h0; otpTimerSel <= 4'h0;
        otpIgnIlim <= 11'h002; otpPowergoodGating <= 1'b0; releaseDue <= 1'b0;
        otpIgnOv <= 11'h004; otpIgnUv <= 11'h008;
        faultIlim <= 11'h000; faultOv <= 11'h000; faultUv <= 11'h000;
        inRange <= 11'h000; enabledSoFar <= 11'h001;
        cyc(2);
        rstn <= 1'b1;
        cyc(1);
        `CHK("hostReset", 1'b0, hostResetOutN);
        `CHK("irqIdle", 1'b1, irqOutN);
        powerUp(4'h3, 4'h1, 1'b0);
        rd(ADDR_LIMIT, v);
        `CHK("limit", 16'h0003, v);
        rd(ADDR_TSEL, v);
        `CHK("tsel", 16'h0001, v);
        rd(ADDR_IGN0, v);
        `CHK("ignIlim", 16'h0002, v);
        rd(4'(ADDR_IGN0 + 1), v);
        `CHK("ignOv", 16'h0004, v);
        rd(4'(ADDR_IGN0 + 2), v);
        `CHK("ignUv", 16'h0008, v);
        // Gating off: release without any regulator in range
        releaseDue <= 1'b1;
        cyc(3);
        `CHK("relNoPg", 1'b1, hostResetOutN);
        `CHK("hostAwake", 1'b1, hostAwake);
        releaseDue <= 1'b0;
        // Held fault: latch, tally, disable, interrupt, then timer expiry
        p0 = pdCount;
        faultIlim <= 11'h001;
        cyc(3);
        `CHK("disable0", 1'b1, regDisable[0]);
        `CHK("irqLow", 1'b0, irqOutN);
        rd(ADDR_LATCH0, v);
        `CHK("latch0", 16'h0001, v);
        rd(ADDR_TALLY, v);
        `CHK("tally1", 16'h0001, v);
        cyc(12);
        `CHK("timerPd", p0 + 1, pdCount);
        faultIlim <= 11'h000;
        wr(ADDR_LATCH0, 16'h0001);
        wr(ADDR_TALLY, 16'h0000);
        cyc(2);
        `CHK("irqClr", 1'b1, irqOutN);
        // Fault gone before a 4 ms window ends
        wr(ADDR_TSEL, 16'h0002);
        p0 = pdCount;
        @(posedge clk);
        faultIlim <= 11'h001;
        cyc(3);
        faultIlim <= 11'h000;
        cyc(30);
        `CHK("shortFlt", p0, pdCount);
        wr(ADDR_LATCH0, 16'h07FF);
        wr(ADDR_TALLY, 16'h0000);
        // Bypassed fault on regulator 1
        i0 = irqCount;
        p0 = pdCount;
        faultIlim <= 11'h002;
        cyc(3);
        `CHK("bypDis", 1'b0, regDisable[1]);
        `CHK("bypIrq", i0 + 1, irqCount);
        rd(ADDR_LATCH0, v);
        `CHK("bypLatch", 16'h0002, v);
        rd(ADDR_TALLY, v);
        `CHK("bypTally", 16'h0000, v);
        wr(ADDR_MASK0, 16'h0002);
        cyc(2);
        `CHK("masked", 1'b1, irqOutN);
        cyc(30);
        `CHK("bypTimer", p0, pdCount);
        faultIlim <= 11'h000;
        wr(ADDR_LATCH0, 16'h07FF);
        wr(ADDR_MASK0, 16'h0000);
        // Over-voltage on regulator 0: bypassed keeps power good, active drops it
        `CHK("pgIdle", 1'b1, powerGoodOut);
        wr(4'(ADDR_IGN0 + 1), 16'h0001);
        faultOv <= 11'h001;
        cyc(3);
        `CHK("pgByp", 1'b1, powerGoodOut);
        wr(4'(ADDR_IGN0 + 1), 16'h0000);
        cyc(2);
        `CHK("pgDrop", 1'b0, powerGoodOut);
        faultOv <= 11'h000;
        wr(4'(ADDR_LATCH0 + 1), 16'h07FF);
        // Tally reaching a limit of 3 with the timer off
        wr(ADDR_TSEL, 16'h000F);
        p0 = pdCount;
        pulses(3);
        cyc(3);
        `CHK("tallyPd", p0 + 1, pdCount);
        rd(ADDR_TALLY, v);
        `CHK("tally3", 16'h0003, v);
        wr(ADDR_LIMIT, 16'h0000);
        wr(ADDR_TALLY, 16'h0000);
        p0 = pdCount;
        pulses(17);
        `CHK("limit0", p0, pdCount);
        // Window length per code, MSC cycles to a millisecond
        for (int k = 0; k <= 10; k++)
        begin
            timeFault(4'(k), 5000);
            `CHK("window", 1'b1, n >= (MSC << k) && n <= (MSC << k) + 4);
        end
        timeFault(TSEL_LONG, 9000);
        `CHK("win2056", 1'b1, n >= 2056 * MSC && n <= 2056 * MSC + 4);
        timeFault(4'hF, 300);
        `CHK("winOff", 300, n);
        // Reserved codes must not arm the timer
        timeFault(4'hC, 300);
        `CHK("winRes", 300, n);
        // Gating on: out of range at release, recovers in the window
        powerUp(4'h0, 4'hF, 1'b1);
        enabledSoFar <= 11'h003;
        inRange <= 11'h001;
        releaseDue <= 1'b1;
        cyc(3);
        `CHK("holdRst", 1'b0, hostResetOutN);
        `CHK("pause", 1'b1, seqPause);
        rd(4'(ADDR_LATCH0 + 2), v);
        `CHK("pgFailLatch", 16'h0002, v);
        inRange <= 11'h003;
        cyc(3);
        `CHK("relGood", 1'b1, hostResetOutN);
        `CHK("resume", 1'b0, seqPause);
        // Gating on: never recovers, so power-up aborts
        inRange <= 11'h001;
        powerUp(4'h0, 4'hF, 1'b1);
        p0 = abCount;
        cyc(16);
        `CHK("abort", p0 + 1, abCount);
        `CHK("abortOff", 11'h003, regDisable & 11'h003);
        `CHK("noRel", 1'b0, hostResetOutN);
        releaseDue <= 1'b0;
        finish_test();
    end
endmodule
`default_nettype wire
